// *** src/xcvr_test_ctrl.sv ***
// Reset, power-down, calibration, reconfiguration and test status control of a transceiver group.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module xcvr_test_ctrl
    import xcvr_test_pkg::*;
#(
    parameter int RCFG_W = 16,
    parameter int OFS_TICK_N = OFS_TICKS,
    parameter int CAL_TICK_N = CAL_TICKS
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic irq_out,
    input wire logic reconfig_clk_in,
    input wire logic [RCFG_W-1:0] reconfig_to_in,
    output logic [RCFG_W-1:0] reconfig_from_out,
    input wire logic cal_clk_in,
    input wire logic rx_bit_valid_in,
    input wire logic rx_bit_in,
    output logic pcs_pwrdn_out,
    output logic high_speed_interface_pwrdn_out,
    output logic cdr_pwrdn_out,
    output logic pcie_pwrdn_out,
    output logic refclk_buf_en_out,
    output logic tx_pcs_rst_out,
    output logic rx_pma_rst_out,
    output logic rx_pcs_rst_out,
    output logic cal_pwrdn_out,
    output logic offset_cancel_run_out,
    output logic test_done_out,
    output logic test_err_out
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [ST_W-1:0] irq_stat_q;
    logic [ST_W-1:0] irq_mask_q;
    logic [RCFG_W-1:0] rcfg_in_q;
    logic [RCFG_W-1:0] rcfg_out_q;
    logic [DATA_W-1:0] rdata_q;
    logic rcfg_clk_q;
    logic cal_clk_q;
    logic [7:0] ofs_cnt_q;
    logic [7:0] cal_cnt_q;
    logic ofs_done_q;
    logic cal_done_q;
    logic [ST_W-1:0] stat_prev_q;
    logic [1:0] rx_rst_age_q;
    logic vf_done;
    logic vf_err;

    wire sel_ctrl = (addr_in == OFS_CTRL);
    wire sel_status = (addr_in == OFS_STATUS);
    wire sel_irq_stat = (addr_in == OFS_IRQ_STAT);
    wire sel_irq_mask = (addr_in == OFS_IRQ_MASK);
    wire sel_rcfg_in = (addr_in == OFS_RCFG_IN);
    wire sel_rcfg_out = (addr_in == OFS_RCFG_OUT);
    wire wr_ctrl = wr_in && sel_ctrl;
    wire wr_mask = wr_in && sel_irq_mask;
    wire wr_rcfg = wr_in && sel_rcfg_out;
    wire rd_irq = rd_in && sel_irq_stat;

    wire block_pwrdn = ctrl_q[CTRL_PWRDN];
    wire pipe_mode = ctrl_q[CTRL_PIPE];
    wire cal_pwrdn = ctrl_q[CTRL_CAL_PWRDN];
    wire test_mode_t mode = test_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);

    // Power-down also forces every coding-layer reset, so no block wakes mid-state.
    wire tx_rst = ctrl_q[CTRL_TX_RST] || block_pwrdn;
    wire rx_ana_rst = ctrl_q[CTRL_RX_ANA_RST] || block_pwrdn;
    wire rx_dig_rst = ctrl_q[CTRL_RX_DIG_RST] || block_pwrdn;

    // Pin inputs are synchronous, so only one register is needed for edge detection.
    wire rcfg_tick = reconfig_clk_in && !rcfg_clk_q;
    wire cal_tick = cal_clk_in && !cal_clk_q;
    // In PIPE mode offset cancellation is not driven by the reconfiguration clock.
    wire ofs_run = !pipe_mode && !block_pwrdn && !ofs_done_q;
    wire cal_run = !cal_pwrdn && !cal_done_q;

    wire [ST_W-1:0] status = {ofs_done_q, cal_done_q, vf_err, vf_done};
    wire [ST_W-1:0] events = status & ~stat_prev_q;
    wire [ST_W-1:0] irq_stat_d = events | (rd_irq ? {ST_W{1'b0}} : irq_stat_q);

    wire [DATA_W-1:0] rd_mux =
        sel_ctrl ? DATA_W'(ctrl_q) :
        sel_status ? DATA_W'(status) :
        sel_irq_stat ? DATA_W'(irq_stat_q) :
        sel_irq_mask ? DATA_W'(irq_mask_q) :
        sel_rcfg_in ? DATA_W'(rcfg_in_q) :
        sel_rcfg_out ? DATA_W'(rcfg_out_q) : {DATA_W{1'b0}};

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= {ST_W{1'b0}};
            rcfg_out_q <= {RCFG_W{1'b0}};
        end else begin
            ctrl_q <= wr_ctrl ? wdata_in[CTRL_W-1:0] : ctrl_q;
            irq_mask_q <= wr_mask ? wdata_in[ST_W-1:0] : irq_mask_q;
            rcfg_out_q <= wr_rcfg ? wdata_in[RCFG_W-1:0] : rcfg_out_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= {DATA_W{1'b0}};
            irq_stat_q <= {ST_W{1'b0}};
            stat_prev_q <= {ST_W{1'b0}};
        end else begin
            rdata_q <= rd_in ? rd_mux : {DATA_W{1'b0}};
            irq_stat_q <= irq_stat_d;
            stat_prev_q <= status;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rcfg_clk_q <= 1'b0;
            rcfg_in_q <= {RCFG_W{1'b0}};
        end else begin
            rcfg_clk_q <= reconfig_clk_in;
            rcfg_in_q <= rcfg_tick ? reconfig_to_in : rcfg_in_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ofs_cnt_q <= 8'h00;
            ofs_done_q <= 1'b0;
        end else if (rx_ana_rst) begin
            ofs_cnt_q <= 8'h00;
            ofs_done_q <= 1'b0;
        end else if (ofs_run && rcfg_tick) begin
            ofs_cnt_q <= ofs_cnt_q + 8'h01;
            ofs_done_q <= (ofs_cnt_q == 8'(OFS_TICK_N - 1));
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cal_clk_q <= 1'b0;
            cal_cnt_q <= 8'h00;
            cal_done_q <= 1'b0;
        end else begin
            cal_clk_q <= cal_clk_in;
            if (cal_pwrdn) begin
                cal_cnt_q <= 8'h00;
                cal_done_q <= 1'b0;
            end else if (cal_run && cal_tick) begin
                cal_cnt_q <= cal_cnt_q + 8'h01;
                cal_done_q <= (cal_cnt_q == 8'(CAL_TICK_N - 1));
            end
        end
    end

    // Software makes each reset pulse; this age counter only serves the width check below.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_rst_age_q <= 2'h0;
        end else begin
            rx_rst_age_q <= !rx_dig_rst ? 2'h0 : ((rx_rst_age_q == 2'h3) ? 2'h3 : rx_rst_age_q + 2'h1);
        end
    end

    prbs_verifier #(
        .PAT_LEN(PRBS_LEN)
    ) u_verifier (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .clear_in(rx_dig_rst),
        .mode_in(mode),
        .bit_valid_in(rx_bit_valid_in && !rx_ana_rst),
        .bit_in(rx_bit_in),
        .done_out(vf_done),
        .err_out(vf_err)
    );

    assign rdata_out = rdata_q;
    assign irq_out = |(irq_stat_q & irq_mask_q);
    assign pcs_pwrdn_out = block_pwrdn;
    assign high_speed_interface_pwrdn_out = block_pwrdn;
    assign cdr_pwrdn_out = block_pwrdn;
    assign pcie_pwrdn_out = block_pwrdn;
    assign refclk_buf_en_out = 1'b1;
    assign tx_pcs_rst_out = tx_rst;
    assign rx_pma_rst_out = rx_ana_rst;
    assign rx_pcs_rst_out = rx_dig_rst;
    assign cal_pwrdn_out = cal_pwrdn;
    assign offset_cancel_run_out = ofs_run;
    assign reconfig_from_out = rcfg_out_q;
    assign test_done_out = vf_done;
    assign test_err_out = vf_err;

    pwrdn_all_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        block_pwrdn |-> (pcs_pwrdn_out && cdr_pwrdn_out && pcie_pwrdn_out && rx_pcs_rst_out))
        else $error("power-down left a path running");
    refclk_on_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        refclk_buf_en_out)
        else $error("reference clock buffer disabled");
    tx_rst_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ctrl_q[CTRL_TX_RST] |-> tx_pcs_rst_out)
        else $error("transmit reset not driven");
    rx_ana_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        rx_pma_rst_out |=> (!ofs_done_q && ofs_cnt_q == 8'h00))
        else $error("analog reset did not restart offset cancellation");
    rx_clear_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        rx_pcs_rst_out |=> (!test_done_out && !test_err_out))
        else $error("receive reset did not clear test flags");
    rst_width_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        $fell(rx_dig_rst) |-> (rx_rst_age_q >= 2'(RST_MIN_CYC)))
        else $error("receive reset pulse shorter than two cycles");
    pipe_ofs_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (pipe_mode && !rx_ana_rst) |=> $stable(ofs_cnt_q))
        else $error("offset cancellation ran in PIPE mode");
    rcfg_sample_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        rcfg_tick |=> (rcfg_in_q == $past(reconfig_to_in)))
        else $error("reconfig bus not sampled on its clock");
    cal_pwrdn_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        cal_pwrdn |=> (cal_cnt_q == 8'h00 && !cal_done_q))
        else $error("calibration ran while powered down");
    cal_clock_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (!cal_tick && !cal_pwrdn) |=> $stable(cal_cnt_q))
        else $error("calibration advanced without its clock");
    done_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (test_done_out && !rx_pcs_rst_out) |=> test_done_out)
        else $error("done fell without receive reset");
    irq_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (rd_irq && events == {ST_W{1'b0}}) |=> (irq_stat_q == {ST_W{1'b0}}))
        else $error("status read did not clear interrupts");

    cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(irq_out));
    cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(ofs_done_q));
    cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(cal_done_q));
endmodule

// *** src/xcvr_test_pkg.sv ***
// Constants, register map and types of the transceiver reset and test status block.
// Overview of operation
// - Power-down stops coding, interface, recovery, PCIe paths.
// - Reference clock buffers stay powered during power-down.
// - Transmit digital reset holds transmit coding blocks.
// - Receive analog reset resets receiver analog front end.
// - Receive digital reset holds receive coding blocks.
// - Reconfig clock drives offset cancellation except PIPE.
// - Reconfig buses to and from controller; input bus sampled on reconfig clock ticks.
// - Calibration unit runs from its own clock.
// - Calibration power-down input stops the calibration unit.
// - Self-test done on full cycle or error.
// - Pattern-test done on full pattern cycle.
// - Done stays high until receive digital reset.
// - Self-test error sticky until receive digital reset.
// - Pattern-test error lasts three cycles, clears when clean.
package xcvr_test_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_RCFG_IN = 8'h10;
    localparam logic [7:0] OFS_RCFG_OUT = 8'h14;
    localparam int CTRL_PWRDN = 0;
    localparam int CTRL_TX_RST = 1;
    localparam int CTRL_RX_ANA_RST = 2;
    localparam int CTRL_RX_DIG_RST = 3;
    localparam int CTRL_CAL_PWRDN = 4;
    localparam int CTRL_PIPE = 5;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RESET = 8'h1F;
    localparam int ST_DONE = 0;
    localparam int ST_ERR = 1;
    localparam int ST_CAL_DONE = 2;
    localparam int ST_OFS_DONE = 3;
    localparam int ST_W = 4;
    localparam int RST_MIN_CYC = 2;
    localparam int ERR_MIN_CYC = 3;
    localparam int PRBS_LEN = 127;
    localparam int OFS_TICKS = 16;
    localparam int CAL_TICKS = 32;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_BIST = 2'h1,
        MODE_PRBS = 2'h2,
        MODE_RSVD = 2'h3
    } test_mode_t;
endpackage

// *** src/prbs_verifier.sv ***
// Serial PRBS7 verifier with done and error flags for self-test and pattern-test modes.
`timescale 1ns/100ps
module prbs_verifier
    import xcvr_test_pkg::*;
#(
    parameter int PAT_LEN = PRBS_LEN
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire test_mode_t mode_in,
    input wire logic bit_valid_in,
    input wire logic bit_in,
    output logic done_out,
    output logic err_out
);
    logic [6:0] sr_q;
    logic [2:0] seed_q;
    logic [7:0] cnt_q;
    logic [1:0] hold_q;
    logic seq_bad_q;
    logic done_q;
    logic err_q;
    wire active = (mode_in == MODE_BIST) || (mode_in == MODE_PRBS);
    wire seeded = (seed_q == 3'h7);
    wire check = active && bit_valid_in && seeded;
    wire mismatch = check && (bit_in != (sr_q[6] ^ sr_q[5]));
    wire cycle_end = check && (cnt_q == 8'(PAT_LEN - 1));
    wire bist = (mode_in == MODE_BIST);
    wire prbs = (mode_in == MODE_PRBS);
    wire done_set = (bist && (cycle_end || mismatch)) || (prbs && cycle_end);
    wire prbs_clean_end = prbs && cycle_end && !seq_bad_q && !mismatch && (hold_q == 2'h0);
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sr_q <= 7'h00;
            seed_q <= 3'h0;
            cnt_q <= 8'h00;
        end else if (clear_in || !active) begin
            sr_q <= 7'h00;
            seed_q <= 3'h0;
            cnt_q <= 8'h00;
        end else if (bit_valid_in) begin
            sr_q <= {sr_q[5:0], bit_in};
            seed_q <= seeded ? seed_q : seed_q + 3'h1;
            cnt_q <= (!seeded || cycle_end) ? 8'h00 : cnt_q + 8'h01;
        end
    end
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            hold_q <= 2'h0;
            seq_bad_q <= 1'b0;
        end else if (clear_in) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            hold_q <= 2'h0;
            seq_bad_q <= 1'b0;
        end else begin
            done_q <= done_q || done_set;
            if (mismatch) begin
                err_q <= 1'b1;
                hold_q <= 2'(ERR_MIN_CYC - 1);
            end else begin
                err_q <= prbs_clean_end ? 1'b0 : err_q;
                hold_q <= (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
            end
            seq_bad_q <= cycle_end ? 1'b0 : (seq_bad_q || mismatch);
        end
    end
    assign done_out = done_q;
    assign err_out = err_q;

    pattern_done_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (prbs && cycle_end && !clear_in) |=> done_out)
        else $error("done did not rise at pattern cycle end");
    bist_err_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (bist && mismatch && !clear_in) |=> (done_out && err_out))
        else $error("self-test error did not raise done and error");
    err_sticky_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (err_out && bist && !clear_in) |=> err_out)
        else $error("self-test error dropped without clear");
    err_min_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (prbs && $rose(err_out)) |-> (err_out || clear_in) [*3])
        else $error("pattern-test error shorter than three cycles");
    cover property (@(posedge sys_clk_in) disable iff (!nrst_in) prbs && $fell(err_out));
    cover property (@(posedge sys_clk_in) disable iff (!nrst_in) bist && $rose(done_out) && !err_out);
endmodule

// *** bench/far_end_model.sv ***
// Far-side model: fabric pattern source, reconfiguration controller and slow clocks.
`timescale 1ns/100ps
module far_end_model (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic flip_in,
    input wire logic [15:0] rcfg_val_in,
    output logic bit_valid_out,
    output logic bit_out,
    output logic reconfig_clk_out,
    output logic cal_clk_out,
    output logic [15:0] reconfig_to_out
);
    logic [6:0] lfsr_q;
    logic [2:0] div_q;
    logic nxt;
    assign nxt = lfsr_q[6] ^ lfsr_q[5];
    assign reconfig_clk_out = div_q[1];
    assign cal_clk_out = div_q[2];
    // The controller word is held as a level, so any tick captures the same value.
    assign reconfig_to_out = rcfg_val_in;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lfsr_q <= 7'h01;
            div_q <= 3'h0;
            bit_valid_out <= 1'b0;
            bit_out <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[5:0], nxt};
            div_q <= div_q + 3'h1;
            bit_valid_out <= 1'b1;
            // A flip corrupts one sent bit but leaves the source sequence intact.
            bit_out <= nxt ^ flip_in;
        end
    end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench of the transceiver reset and test status block.
`timescale 1ns/100ps
module tb_top
    import xcvr_test_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic wr = 1'b0, rd = 1'b0, flip = 1'b0;
    logic [15:0] rcfg_val = 16'h0;
    logic [DATA_W-1:0] rdata;
    logic irq, rcfg_clk, cal_clk, bv, bt, refclk_en, ofs_run, done, err;
    logic [15:0] rcfg_to, rcfg_from;
    logic [3:0] pd, rst4;
    int miscompares = 0, checks = 0, cycles = 0, i;

    xcvr_test_ctrl #(.RCFG_W(16), .OFS_TICK_N(2), .CAL_TICK_N(2)) DUT (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
        .reconfig_clk_in(rcfg_clk), .reconfig_to_in(rcfg_to), .reconfig_from_out(rcfg_from),
        .cal_clk_in(cal_clk), .rx_bit_valid_in(bv), .rx_bit_in(bt),
        .pcs_pwrdn_out(pd[0]), .high_speed_interface_pwrdn_out(pd[1]), .cdr_pwrdn_out(pd[2]),
        .pcie_pwrdn_out(pd[3]), .refclk_buf_en_out(refclk_en), .tx_pcs_rst_out(rst4[0]),
        .rx_pma_rst_out(rst4[1]), .rx_pcs_rst_out(rst4[2]), .cal_pwrdn_out(rst4[3]),
        .offset_cancel_run_out(ofs_run), .test_done_out(done), .test_err_out(err)
    );
    far_end_model far_end (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .flip_in(flip), .rcfg_val_in(rcfg_val),
        .bit_valid_out(bv), .bit_out(bt), .reconfig_clk_out(rcfg_clk), .cal_clk_out(cal_clk),
        .reconfig_to_out(rcfg_to)
    );

    always #20 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask
    task flip_bit;
        @(posedge sys_clk_in);
        flip <= 1'b1;
        @(posedge sys_clk_in);
        flip <= 1'b0;
    endtask
    // Bounded wait for a verifier flag; the caller still compares afterwards.
    task wait_sig(input int which, input logic v, input int lim);
        for (i = 0; i < lim; i++) begin
            if ((which == 1 ? err : done) === v) break;
            tick(1);
        end
    endtask
    task test_end(input string nm);
        $display("test %s finished", nm);
    endtask
    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        tick(15);
        chk("reset outputs", 32'h1F, 32'({refclk_en, rst4}));
        chk("reset power-down", 32'hF, 32'(pd));
        @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        rd_reg(OFS_CTRL, 32'h1F, "ctrl reset");
        rd_reg(OFS_IRQ_MASK, 32'h0, "mask reset");
        rd_reg(8'h20, 32'h0, "unmapped");
        wr_reg(OFS_RCFG_IN, 32'hABCD);
        rd_reg(OFS_RCFG_IN, 32'h0, "reconfig in read-only");
        test_end("reset");
        for (int b = 1; b <= 4; b++) begin
            wr_reg(OFS_CTRL, 32'(1 << b));
            tick(3);
            chk("reset outputs", 32'(1 << (b - 1)), 32'(rst4));
            chk("power-down outputs", 32'h0, 32'(pd));
        end
        wr_reg(OFS_CTRL, 32'h01);
        tick(3);
        chk("power-down all", 32'h1F, 32'({refclk_en, pd}));
        chk("power-down resets", 32'h7, 32'(rst4[2:0]));
        test_end("reset and power-down");
        rcfg_val <= 16'h5A3C;
        wr_reg(OFS_CTRL, 32'h00);
        tick(2);
        chk("offset run", 32'h1, 32'(ofs_run));
        wr_reg(OFS_RCFG_OUT, 32'h0000C3A5);
        tick(30);
        chk("offset run ended", 32'h0, 32'(ofs_run));
        chk("reconfig out", 32'hC3A5, 32'(rcfg_from));
        rd_reg(OFS_RCFG_IN, 32'h5A3C, "reconfig in");
        rd_reg(OFS_STATUS, 32'hC, "status cal and offset");
        chk("irq masked", 32'h0, 32'(irq));
        wr_reg(OFS_IRQ_MASK, 32'h4);
        tick(1);
        chk("irq unmasked", 32'h1, 32'(irq));
        rd_reg(OFS_IRQ_STAT, 32'hC, "irq status");
        tick(1);
        chk("irq after clear", 32'h0, 32'(irq));
        rd_reg(OFS_IRQ_STAT, 32'h0, "irq status cleared");
        wr_reg(OFS_CTRL, 32'h24);
        wr_reg(OFS_CTRL, 32'h20);
        tick(30);
        chk("offset run pipe", 32'h0, 32'(ofs_run));
        rd_reg(OFS_STATUS, 32'h4, "status pipe");
        test_end("reconfiguration and interrupts");
        wr_reg(OFS_CTRL, 32'h80);
        tick(120);
        chk("done early", 32'h0, 32'(done));
        wait_sig(0, 1'b1, 40);
        chk("done", 32'h1, 32'(done));
        flip_bit();
        wait_sig(1, 1'b1, 12);
        chk("pattern err", 32'h1, 32'(err));
        repeat (2) begin
            tick(1);
            chk("pattern err hold", 32'h1, 32'(err));
        end
        wait_sig(1, 1'b0, 300);
        chk("pattern err cleared", 32'h0, 32'(err));
        chk("done held", 32'h1, 32'(done));
        wr_reg(OFS_CTRL, 32'h88);
        tick(2);
        chk("flags cleared", 32'h0, 32'({done, err}));
        test_end("pattern test");
        wr_reg(OFS_CTRL, 32'h40);
        tick(20);
        flip_bit();
        wait_sig(1, 1'b1, 12);
        tick(1);
        chk("self-test err and done", 32'h3, 32'({done, err}));
        tick(300);
        chk("self-test sticky", 32'h3, 32'({done, err}));
        wr_reg(OFS_CTRL, 32'h48);
        tick(2);
        chk("self-test cleared", 32'h0, 32'({done, err}));
        wr_reg(OFS_CTRL, 32'h40);
        wait_sig(0, 1'b1, 160);
        chk("self-test clean done", 32'h2, 32'({done, err}));
        // A two-cycle receive reset is the shortest legal pulse; the reserved mode must leave the verifier idle.
        wr_reg(OFS_CTRL, 32'hC8);
        wr_reg(OFS_CTRL, 32'hC0);
        tick(150);
        chk("reserved mode idle", 32'h0, 32'({done, err}));
        test_end("self-test");
        summarize();
    end
endmodule
